//--- design/dssp_pkg.sv
`default_nettype none
package dssp_pkg;
	// timing
	localparam int CLK_HZ = 20_000_000;
	localparam int LS_HZ  = 32_768;
	localparam int LS_DIV = CLK_HZ / LS_HZ;
	localparam int LS_CNT_W = 10;

	// register indices, byte address is four times the index
	localparam logic [15:0] CH0_BUFFER_LOW_IDX  = 16'hF280;
	localparam logic [15:0] CH0_BUFFER_HIGH_IDX = 16'hF281;
	localparam logic [15:0] CH0_CONTROL_IDX     = 16'hF282;
	localparam logic [15:0] CH0_MODE_FIRST_IDX  = 16'hF284;
	localparam logic [15:0] CH0_MODE_SECOND_IDX = 16'hF285;
	localparam logic [15:0] CH1_BUFFER_LOW_IDX  = 16'hF288;
	localparam logic [15:0] CH1_BUFFER_HIGH_IDX = 16'hF289;
	localparam logic [15:0] CH1_CONTROL_IDX     = 16'hF28A;
	localparam logic [15:0] CH1_MODE_FIRST_IDX  = 16'hF28C;
	localparam logic [15:0] CH1_MODE_SECOND_IDX = 16'hF28D;
	localparam logic [15:0] BLOCK_CONTROL_TWO_IDX = 16'hF290;

	// field positions and reset values
	localparam int START_BIT   = 0;
	localparam int DIR_BIT     = 0;
	localparam int MD_LSB      = 1;
	localparam int LG_BIT      = 3;
	localparam int CKSEL_LSB   = 0;
	localparam int CKT_BIT     = 4;
	localparam int NEG_BIT     = 5;
	localparam logic [7:0] REG_RESET = 8'h00;

	// clock select codes that pick the external clock pin
	localparam logic [3:0] CK_EXT_A = 4'h6;
	localparam logic [3:0] CK_EXT_B = 4'h7;

	typedef enum logic [1:0] {
		MD_STOP = 2'b00,
		MD_RX   = 2'b01,
		MD_TX   = 2'b10,
		MD_TXRX = 2'b11
	} dssp_dir_type;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} dssp_state_type;

	typedef struct packed {
		logic         neg;
		logic         ckt;
		logic [3:0]   cksel;
		logic         lg;
		dssp_dir_type md;
		logic         msb_first;
	} dssp_cfg_type;
endpackage
`default_nettype wire

//--- design/dssp_rate_gen.sv
`default_nettype none
module dssp_rate_gen (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	output logic      [15:0] tick_o
);
	logic [dssp_pkg::LS_CNT_W-1:0] ls_cnt;
	logic                          ls_tick;
	logic                          ls_half;
	logic [4:0]                    hs_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ls_cnt  <= '0;
			ls_tick <= 1'b0;
			ls_half <= 1'b0;
			hs_cnt  <= 5'h00;
		end else begin
			hs_cnt  <= hs_cnt + 5'h01;
			ls_tick <= 1'b0;
			if (ls_cnt == dssp_pkg::LS_CNT_W'(dssp_pkg::LS_DIV - 1)) begin
				ls_cnt  <= '0;
				ls_tick <= 1'b1;
				ls_half <= ~ls_half;
			end else begin
				ls_cnt <= ls_cnt + 1'b1;
			end
		end
	end

	// one enable per clock select code, half periods of the serial clock
	assign tick_o[0]     = ls_tick;
	assign tick_o[1]     = ls_tick & ls_half;
	assign tick_o[2]     = hs_cnt[1:0] == 2'h3;
	assign tick_o[3]     = hs_cnt[2:0] == 3'h7;
	assign tick_o[4]     = hs_cnt[3:0] == 4'hF;
	assign tick_o[5]     = hs_cnt == 5'h1F;
	assign tick_o[7:6]   = 2'h0;
	assign tick_o[8]     = 1'b1;
	assign tick_o[9]     = hs_cnt[0];
	// prohibited codes get no enable, so the channel simply stalls
	assign tick_o[15:10] = 6'h00;
endmodule
`default_nettype wire

//--- design/dssp_top.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Function
// - two independent channels, each shifting 8 or 16 bit words.
// - a channel works only while its block disable bit is 0.
// - disable bit 1 holds every channel register in reset.
// - each channel is master driving clock or slave taking it.
// - bit order selectable, most or least significant first.
// - word length selectable, 8 or 16 bits per transfer.
// - clock and data timing follow SPI mode 0 or mode 3 only.
// - buffer byte writes load the transmit shift register bytes.
// - buffer byte reads return the receive register bytes.
// - low byte bits 7..0 8/16 bit access; high byte 8 bit only.
// - writing 1 to control bit 0 starts one transfer unless the direction field is stop.
// - hardware clears the start bit when the transfer completes.
// - reset clears start bit and all registers to 00H.
// - each channel has data in, two way clock and data out.
// - direction field: stop, receive, transmit, both.
// - internal clock select means master, external pin slave.
// - master clock type 0 idles high mode 3, 1 idles low mode 0.
module dssp_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [17:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [1:0]  serial_in_i,
	input  wire logic [1:0]  serial_clock_i,
	output logic      [1:0]  serial_clock_o,
	output logic      [1:0]  serial_clock_oe_o,
	output logic      [1:0]  serial_out_o
);
	////////////////////////////////////////////////////////////////////////
	// bus decode

	logic [1:0]  block_disable;
	logic [15:0] tick;
	logic [31:0] ch_rd [2];
	logic [31:0] rd_data;
	wire         access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire         wr     = access & wb_we_i;
	wire  [15:0] idx    = wb_adr_i[17:2];
	wire         hit_blk = idx == dssp_pkg::BLOCK_CONTROL_TWO_IDX;

	localparam logic [15:0] BUFL_IDX [2] = '{dssp_pkg::CH0_BUFFER_LOW_IDX,
		dssp_pkg::CH1_BUFFER_LOW_IDX};
	localparam logic [15:0] BUFH_IDX [2] = '{dssp_pkg::CH0_BUFFER_HIGH_IDX,
		dssp_pkg::CH1_BUFFER_HIGH_IDX};
	localparam logic [15:0] CON_IDX [2] = '{dssp_pkg::CH0_CONTROL_IDX,
		dssp_pkg::CH1_CONTROL_IDX};
	localparam logic [15:0] MOD0_IDX [2] = '{dssp_pkg::CH0_MODE_FIRST_IDX,
		dssp_pkg::CH1_MODE_FIRST_IDX};
	localparam logic [15:0] MOD1_IDX [2] = '{dssp_pkg::CH0_MODE_SECOND_IDX,
		dssp_pkg::CH1_MODE_SECOND_IDX};

	assign rd_data = ch_rd[0] | ch_rd[1] |
		(hit_blk ? {30'h00000000, block_disable} : 32'h00000000);

	// unmapped indices answer with zero data and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o      <= 1'b0;
			wb_dat_o      <= 32'h00000000;
			block_disable <= 2'h0;
		end else begin
			wb_ack_o <= access;
			wb_dat_o <= access ? rd_data : 32'h00000000;
			if (wr && hit_blk && wb_sel_i[0])
				block_disable <= wb_dat_i[1:0];
		end
	end

	dssp_rate_gen u_rate (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.tick_o (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// channels

	for (genvar c = 0; c < 2; c++) begin : ch_g
		dssp_pkg::dssp_state_type state;
		dssp_pkg::dssp_cfg_type   cfg;
		logic [15:0] tx_shift;
		logic [15:0] rx;
		logic [15:0] sh;
		logic [3:0]  mode_first;
		logic [5:0]  mode_second;
		logic        start;
		logic [4:0]  hcnt;
		logic [4:0]  rcnt;
		logic        in_s1;
		logic        in_s2;
		logic        ck_s1;
		logic        ck_s2;
		logic        ck_s3;

		// held in reset by system reset or by its disable bit
		wire srst = rst_i | block_disable[c];

		wire hit_bufl = idx == BUFL_IDX[c];
		wire hit_bufh = idx == BUFH_IDX[c];
		wire hit_con  = idx == CON_IDX[c];
		wire hit_mod0 = idx == MOD0_IDX[c];
		wire hit_mod1 = idx == MOD1_IDX[c];

		assign cfg = {mode_second, mode_first};
		wire running = state == dssp_pkg::ST_RUN;
		wire master  = cfg.cksel != dssp_pkg::CK_EXT_A &&
			cfg.cksel != dssp_pkg::CK_EXT_B;
		wire tk      = tick[cfg.cksel];
		wire [4:0] nbits  = cfg.lg ? 5'd16 : 5'd8;
		wire [4:0] last_h = cfg.lg ? 5'd31 : 5'd15;

		// bit order and length pick the outgoing bit and shift form
		wire out_bit = cfg.msb_first ? (cfg.lg ? sh[15] : sh[7]) :
			sh[0];
		wire first_bit = cfg.msb_first ?
			(cfg.lg ? tx_shift[15] : tx_shift[7]) : tx_shift[0];
		wire [15:0] shifted = cfg.msb_first ? {sh[14:0], in_s2} :
			(cfg.lg ? {in_s2, sh[15:1]} :
			{8'h00, in_s2, sh[7:1]});

		// master: sample on rising, change on falling serial clock
		wire m_tick   = running & master & tk;
		wire m_sample = m_tick & (cfg.ckt ? ~hcnt[0] : hcnt[0]);
		wire m_change = m_tick & (cfg.ckt ? hcnt[0] :
			(~hcnt[0] & (hcnt != 5'd0)));
		wire m_done   = m_tick & (hcnt == last_h);

		// slave: same edges, clock type ignored
		wire rise     = ck_s2 & ~ck_s3;
		wire fall     = ~ck_s2 & ck_s3;
		wire s_sample = running & ~master & rise;
		wire s_change = running & ~master & fall & (rcnt != 5'd0);
		wire s_done   = s_sample & (rcnt == nbits - 5'd1);

		wire sample = m_sample | s_sample;
		wire change = m_change | s_change;
		wire done   = m_done | s_done;
		wire [15:0] next_sh = sample ? shifted : sh;
		wire tx_on  = cfg.md[1];
		wire go     = wr && hit_con && wb_sel_i[0] &&
			wb_dat_i[dssp_pkg::START_BIT] &&
			cfg.md != dssp_pkg::MD_STOP;

		assign ch_rd[c] =
			hit_bufl ? {16'h0000, rx} :
			hit_bufh ? {24'h000000, rx[15:8]} :
			hit_con  ? {31'h00000000, start} :
			hit_mod0 ? {18'h00000, mode_second, 4'h0, mode_first} :
			hit_mod1 ? {26'h0000000, mode_second} : 32'h00000000;

		// data pin passes two flip-flops and only the second is read; clock pin passes three, edges use the last two
		always_ff @(posedge clk_i) begin
			if (srst) begin
				in_s1 <= 1'b0;
				in_s2 <= 1'b0;
				ck_s1 <= 1'b0;
				ck_s2 <= 1'b0;
				ck_s3 <= 1'b0;
			end else begin
				in_s1 <= serial_in_i[c];
				in_s2 <= in_s1;
				ck_s1 <= serial_clock_i[c];
				ck_s2 <= ck_s1;
				ck_s3 <= ck_s2;
			end
		end

		// software registers
		always_ff @(posedge clk_i) begin
			if (srst) begin
				tx_shift    <= {dssp_pkg::REG_RESET, dssp_pkg::REG_RESET};
				mode_first  <= dssp_pkg::REG_RESET[3:0];
				mode_second <= dssp_pkg::REG_RESET[5:0];
			end else if (wr) begin
				if (hit_bufl && wb_sel_i[0])
					tx_shift[7:0] <= wb_dat_i[7:0];
				if (hit_bufl && wb_sel_i[1])
					tx_shift[15:8] <= wb_dat_i[15:8];
				if (hit_bufh && wb_sel_i[0])
					tx_shift[15:8] <= wb_dat_i[7:0];
				if (hit_mod0 && wb_sel_i[0])
					mode_first <= wb_dat_i[3:0];
				if (hit_mod0 && wb_sel_i[1])
					mode_second <= wb_dat_i[13:8];
				if (hit_mod1 && wb_sel_i[0])
					mode_second <= wb_dat_i[5:0];
			end
		end

		// transfer engine
		always_ff @(posedge clk_i) begin
			if (srst) begin
				state <= dssp_pkg::ST_IDLE;
				start <= 1'b0;
				rx    <= {dssp_pkg::REG_RESET, dssp_pkg::REG_RESET};
				sh    <= 16'h0000;
				hcnt  <= 5'd0;
				rcnt  <= 5'd0;
			end else begin
				case (state)
				dssp_pkg::ST_IDLE: begin
					if (go) begin
						state <= dssp_pkg::ST_RUN;
						start <= 1'b1;
						sh    <= tx_shift;
						hcnt  <= 5'd0;
						rcnt  <= 5'd0;
					end
				end
				dssp_pkg::ST_RUN: begin
					sh <= next_sh;
					if (m_tick)
						hcnt <= hcnt + 5'd1;
					if (s_sample)
						rcnt <= rcnt + 5'd1;
					if (done) begin
						state <= dssp_pkg::ST_IDLE;
						start <= 1'b0;
						if (cfg.md[0])
							rx <= cfg.lg ? next_sh :
								{8'h00, next_sh[7:0]};
					end
				end
				default: state <= dssp_pkg::ST_IDLE;
				endcase
			end
		end

		// pins; a transmit-off channel drives its data line high once a transfer starts
		always_ff @(posedge clk_i) begin
			if (srst) begin
				serial_out_o[c]      <= 1'b1;
				serial_clock_o[c]    <= 1'b0;
				serial_clock_oe_o[c] <= 1'b0;
			end else begin
				serial_clock_oe_o[c] <= master;
				if (!running) begin
					serial_clock_o[c] <= master & ~cfg.ckt;
					serial_out_o[c]   <= go ? (tx_on ? first_bit : 1'b1) :
						serial_out_o[c];
				end else begin
					if (m_tick)
						serial_clock_o[c] <= ~serial_clock_o[c];
					if (change)
						serial_out_o[c] <= tx_on ? out_bit : 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/dssp_top_assertions.sv
`default_nettype none
module dssp_top_assertions (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [17:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic [1:0]  serial_clock_oe_o,
	input  wire logic [1:0]  serial_out_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire [15:0] idx = wb_adr_i[17:2];
	wire        rd  = req && !wb_we_i && idx[15:4] == 12'hF28;
	a_ack_after_req: assert property (req |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_has_cause: assert property (wb_ack_o |-> $past(req))
		else $error("ack without request");
	a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_gap_reads_zero: assert property (rd && idx[1:0] == 2'h3
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_high_byte_only: assert property (rd && idx[2:0] == 3'h1
		|=> wb_dat_o[31:8] == 24'h0) else $error("high byte too wide");
	a_ctrl_one_bit: assert property (rd && idx[2:0] == 3'h2
		|=> wb_dat_o[31:1] == 31'h0) else $error("control extra bits");
	a_reset_pins_idle: assert property ($fell(rst_i) |->
		serial_out_o == 2'h3 && serial_clock_oe_o == 2'h0)
		else $error("pins not idle after reset");
endmodule
bind dssp_top dssp_top_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
	.serial_clock_oe_o, .serial_out_o);
`default_nettype wire

//--- tb/dssp_spi_peer.sv
`default_nettype none
module dssp_spi_peer (
	input  wire logic        sck_i,
	input  wire logic        mosi_i,
	input  wire logic        load_i,
	input  wire logic        msb_i,
	input  wire logic        lg_i,
	input  wire logic        en_i,
	input  wire logic [15:0] word_i,
	output logic             miso_o,
	output logic      [15:0] cap_o,
	output logic      [4:0]  cnt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       drv = 1'b1;
	wire  [4:0] n   = lg_i ? 5'h10 : 5'h08;
	wire  [4:0] pos = load_i ? 5'h00 : cnt_o;
	wire  [4:0] bi  = msb_i ? n - pos - 5'h01 : pos;
	// sample on rise, change on fall: mode 0 and 3 alike
	always @(posedge sck_i or posedge load_i) begin
		if (load_i) begin
			cnt_o <= 5'h00;
			cap_o <= 16'h0000;
		end else begin
			cnt_o <= cnt_o + 5'h01;
			cap_o <= msb_i ? {cap_o[14:0], mosi_i} : {mosi_i, cap_o[15:1]};
		end
	end
	always @(negedge sck_i or posedge load_i) begin
		drv <= word_i[bi[3:0]];
	end
	// no select pin; framed by en_i, inverse shown when released
	assign miso_o = en_i ? drv : ~drv;
endmodule
`default_nettype wire

//--- tb/dssp_top_tb_top.sv
`default_nettype none
module dssp_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, rst_i, cyc, stb, we, load, pmsb, plg, en, ack;
	logic [17:0] adr;
	logic [3:0]  sel;
	logic [31:0] dat, dat_o, q, seed;
	logic [15:0] word, last [2], cap [2];
	logic [4:0]  cnt [2];
	logic [1:0]  sck_o, oe, sout, tsck;
	wire  [1:0]  sin;
	wire  [1:0]  sck = (oe & sck_o) | (~oe & tsck);
	int          err_count, cmp_count;
	dssp_top u_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .serial_in_i(sin),
		.serial_clock_i(sck), .serial_clock_o(sck_o),
		.serial_clock_oe_o(oe), .serial_out_o(sout));
	for (genvar g = 0; g < 2; g++) begin : g_peer
		dssp_spi_peer u_peer (.sck_i(sck[g]), .mosi_i(sout[g]), .load_i(load),
			.msb_i(pmsb), .lg_i(plg), .en_i(en), .word_i(word),
			.miso_o(sin[g]), .cap_o(cap[g]), .cnt_o(cnt[g]));
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic end_of_test();
		$display("errors %0d checks %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [15:0] i,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, sel, dat} <= {2'h3, w, i, 2'h0, s, d};
		do @(posedge clk_i); while (ack !== 1'b1 && n++ < 20);
		// a slave that never answers is a mismatch, not a silent pass
		if (ack !== 1'b1) begin
			err_count++;
			$display("ERROR %0t no ack", $time);
		end
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic xfer(input int c, input logic lg, input logic msb,
		input logic [1:0] md, input logic sl);
		logic [31:0] r;
		logic [15:0] b, m;
		logic [3:0]  ck;
		int          n, k;
		r = rnd();
		b = c ? dssp_pkg::CH1_BUFFER_LOW_IDX : dssp_pkg::CH0_BUFFER_LOW_IDX;
		m = lg ? 16'hFFFF : 16'h00FF;
		n = lg ? 16 : 8;
		k = 0;
		ck = sl ? 4'h6 : (r[2] ? 4'h2 : 4'h4);
		tsck[c] <= ~r[4];
		// mode set before start, untouched while running
		bus(1'b1, b + 16'h4, 4'h3, {19'h0, r[4], ck, 4'h0, lg, md, msb});
		if (r[1]) bus(1'b1, b, 4'h3, {16'h0, r[15:0]});
		else begin
			bus(1'b1, b, 4'h1, {24'h0, r[7:0]});
			bus(1'b1, b + 16'h1, 4'h1, {24'h0, r[15:8]});
		end
		{word, pmsb, plg, load, en} <= {r[31:16], msb, lg, 2'h3};
		@(posedge clk_i);
		load <= 1'b0;
		bus(1'b1, b + 16'h2, 4'h1, 32'h1);
		bus(1'b0, b + 16'h2, 4'h1, 32'h0);
		chk(q, md != 2'h0);
		chk(oe[c], !sl);
		if (sl && md != 2'h0) repeat (2 * n) begin
			repeat (8) @(posedge clk_i);
			tsck[c] <= ~tsck[c];
		end
		do bus(1'b0, b + 16'h2, 4'h1, 32'h0); while (q[0] && k++ < 400);
		chk(q, 32'h0);
		en <= 1'b0;
		chk(cnt[c], md != 2'h0 ? n : 0);
		if (md[0]) last[c] = r[31:16] & m;
		bus(1'b0, b, 4'h3, 32'h0);
		chk(q, last[c]);
		bus(1'b0, b + 16'h1, 4'h1, 32'h0);
		chk(q, last[c][15:8]);
		if (md != 2'h0) chk(msb ? cap[c] : cap[c] >> (16 - n),
			md[1] ? r[15:0] & m : m);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		end_of_test();
	end
	initial begin
		{rst_i, cyc, stb, we, load, pmsb, plg, en} = 8'h80;
		{adr, sel, dat, word, tsck, seed} = {72'h0, 32'h43};
		last = '{16'h0, 16'h0};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b1, 16'hF283, 4'h3, 32'hFF);
		for (int i = 0; i < 17; i++) begin
			bus(1'b0, 16'(16'hF280 + i), 4'h3, 32'h0);
			chk(q, 32'h0);
		end
		$display("test reset done");
		for (int c = 0; c < 2; c++)
			for (int v = 0; v < 32; v++)
				xfer(c, v[4], v[3], v[2:1], v[0]);
		$display("test transfers done");
		bus(1'b1, dssp_pkg::BLOCK_CONTROL_TWO_IDX, 4'h1, 32'h1);
		// pins settle one edge after the disable lands
		@(posedge clk_i);
		chk({oe[0], sout[0]}, 2'h1);
		bus(1'b1, dssp_pkg::CH0_CONTROL_IDX, 4'h1, 32'h1);
		bus(1'b0, dssp_pkg::CH0_CONTROL_IDX, 4'h1, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, dssp_pkg::CH1_BUFFER_LOW_IDX, 4'h3, 32'h0);
		chk(q, last[1]);
		bus(1'b1, dssp_pkg::BLOCK_CONTROL_TWO_IDX, 4'h1, 32'h0);
		bus(1'b0, dssp_pkg::CH0_MODE_FIRST_IDX, 4'h3, 32'h0);
		chk(q, 32'h0);
		$display("test disable done");
		end_of_test();
	end
endmodule
`default_nettype wire
